// [verilog/dtd_decoder.v]
`include "dtd_defines.vh"

module dtd_decoder (
   input  wire       clk_i,
   input  wire       rst_n_i,
   input  wire [7:0] byte_i,
   input  wire       byte_valid_i,
   output wire       byte_ready_o,
   output reg        op_valid_o,
   input  wire       op_ready_i,
   output reg  [3:0] op_kind_o,
   output reg        op_word_o,
   output reg  [1:0] op_mode_o,
   output reg  [2:0] op_reg_o,
   output reg  [2:0] op_rm_o,
   output reg  [15:0] op_imm_o,
   output reg  [4:0] op_clocks_o,
   output reg        op_seg_ovr_o,
   output reg  [1:0] op_seg_o,
   output reg        pfx_valid_o,
   output reg  [4:0] pfx_clocks_o
);

   // Sequencer states
   localparam ST_OPC   = 3'h0;
   localparam ST_MODRM = 3'h1;
   localparam ST_IMM_L = 3'h2;
   localparam ST_IMM_H = 3'h3;
   localparam ST_OUT   = 3'h4;

   // Classes of a first byte
   localparam CL_PREFIX = 2'h0;
   localparam CL_SINGLE = 2'h1;
   localparam CL_MODRM  = 2'h2;
   localparam CL_BAD    = 2'h3;

   // Sequencer and prefix state
   reg  [2:0]  state;
   reg  [7:0]  opc;
   reg         ovr_pend;
   reg  [1:0]  ovr_seg;

   // Next values of every register
   reg  [2:0]  next_state;
   reg  [7:0]  next_opc;
   reg         next_ovr_pend;
   reg  [1:0]  next_ovr_seg;
   reg         next_op_valid;
   reg  [3:0]  next_op_kind;
   reg         next_op_word;
   reg  [1:0]  next_op_mode;
   reg  [2:0]  next_op_reg;
   reg  [2:0]  next_op_rm;
   reg  [15:0] next_op_imm;
   reg  [4:0]  next_op_clocks;
   reg         next_op_seg_ovr;
   reg  [1:0]  next_op_seg;
   reg         next_pfx_valid;
   reg  [4:0]  next_pfx_clocks;

   // First byte classification
   reg  [1:0]  opc_class;
   reg  [3:0]  single_kind;
   reg  [4:0]  single_clocks;

   // Addressing byte fields and costs
   wire        take;
   wire [1:0]  mb_mode;
   wire [2:0]  mb_reg;
   wire [2:0]  mb_rm;
   wire        mb_is_reg;
   wire [4:0]  ldseg_cost;
   wire [4:0]  stseg_cost;
   wire [4:0]  movimm_cost;

   // Bytes accepted only while assembling an instruction
   assign byte_ready_o = (state != ST_OUT);
   assign take         = byte_valid_i && byte_ready_o;
   assign mb_mode      = byte_i[`DTD_MOD_HI:`DTD_MOD_LO];
   assign mb_reg       = byte_i[`DTD_REG_HI:`DTD_REG_LO];
   assign mb_rm        = byte_i[2:0];
   assign mb_is_reg    = (mb_mode == `DTD_MOD_REG);

   // Width bit of the opcode picks the immediate move cost
   assign movimm_cost  = opc[0] ? `DTD_CLK_MOVIMM_W : `DTD_CLK_MOVIMM_B;

   // Register or memory forms of the segment moves
   dtd_cost_sel u_ldseg (
      .mode_i     (mb_mode),
      .reg_cost_i (`DTD_CLK_LDSEG_R),
      .mem_cost_i (`DTD_CLK_LDSEG_M),
      .cost_o     (ldseg_cost)
   );
   dtd_cost_sel u_stseg (
      .mode_i     (mb_mode),
      .reg_cost_i (`DTD_CLK_STSEG_R),
      .mem_cost_i (`DTD_CLK_STSEG_M),
      .cost_o     (stseg_cost)
   );

   // Sort a first byte: prefix, complete, needs addressing byte, unknown
   always @* begin
      opc_class     = CL_BAD;
      single_kind   = `DTD_K_ILLEGAL;
      single_clocks = 5'h00;
      case (byte_i)
         `DTD_PFX_CODE, `DTD_PFX_STACK,
         `DTD_PFX_DATA, `DTD_PFX_EXTRA: begin
            opc_class = CL_PREFIX;
         end
         `DTD_OP_TABLE_LOOKUP: begin
            opc_class     = CL_SINGLE;
            single_kind   = `DTD_K_TBL;
            single_clocks = `DTD_CLK_TBL;
         end
         `DTD_OP_FLAGS_TO_ACCH: begin
            opc_class     = CL_SINGLE;
            single_kind   = `DTD_K_F2AH;
            single_clocks = `DTD_CLK_F2AH;
         end
         `DTD_OP_ACCH_TO_FLAGS: begin
            opc_class     = CL_SINGLE;
            single_kind   = `DTD_K_AH2F;
            single_clocks = `DTD_CLK_AH2F;
         end
         `DTD_OP_MOV_RM_SEG, `DTD_OP_MOV_SEG_RM, `DTD_OP_LOAD_EO,
         `DTD_OP_LOAD_FP_DATA, `DTD_OP_LOAD_FP_EXTRA,
         {`DTD_OP_MOV_IMM_RM, 1'b0}, {`DTD_OP_MOV_IMM_RM, 1'b1}: begin
            opc_class = CL_MODRM;
         end
         default: begin
            opc_class = CL_BAD;
         end
      endcase
   end

   // Next state and result of the decode sequencer
   always @* begin
      next_state      = state;
      next_opc        = opc;
      next_ovr_pend   = ovr_pend;
      next_ovr_seg    = ovr_seg;
      next_op_valid   = op_valid_o;
      next_op_kind    = op_kind_o;
      next_op_word    = op_word_o;
      next_op_mode    = op_mode_o;
      next_op_reg     = op_reg_o;
      next_op_rm      = op_rm_o;
      next_op_imm     = op_imm_o;
      next_op_clocks  = op_clocks_o;
      next_op_seg_ovr = op_seg_ovr_o;
      next_op_seg     = op_seg_o;
      next_pfx_valid  = 1'b0;
      next_pfx_clocks = pfx_clocks_o;
      case (state)
         ST_OPC: begin
            if (take) begin
               next_opc     = byte_i;
               next_op_word = byte_i[0];
               next_op_imm  = 16'h0000;
               next_op_mode = 2'h0;
               next_op_reg  = 3'h0;
               next_op_rm   = 3'h0;
               case (opc_class)
                  CL_PREFIX: begin
                     // A later prefix replaces an earlier one
                     next_ovr_pend   = 1'b1;
                     next_ovr_seg    = byte_i[4:3];
                     next_pfx_valid  = 1'b1;
                     next_pfx_clocks = `DTD_CLK_PREFIX;
                  end
                  CL_SINGLE: begin
                     next_op_kind   = single_kind;
                     next_op_word   = 1'b0;
                     next_op_clocks = single_clocks;
                     next_state     = ST_OUT;
                  end
                  CL_MODRM: begin
                     next_state = ST_MODRM;
                  end
                  default: begin
                     next_op_kind   = `DTD_K_ILLEGAL;
                     next_op_clocks = 5'h00;
                     next_state     = ST_OUT;
                  end
               endcase
            end
         end
         ST_MODRM: begin
            if (take) begin
               next_op_mode = mb_mode;
               next_op_reg  = mb_reg;
               next_op_rm   = mb_rm;
               next_op_word = 1'b1;
               next_state   = ST_OUT;
               case (opc)
                  `DTD_OP_MOV_RM_SEG: begin
                     // Segment field top bit must be zero
                     if (mb_reg[2]) begin
                        next_op_kind   = `DTD_K_ILLEGAL;
                        next_op_clocks = 5'h00;
                     end else begin
                        next_op_kind   = `DTD_K_LDSEG;
                        next_op_clocks = ldseg_cost;
                     end
                  end
                  `DTD_OP_MOV_SEG_RM: begin
                     if (mb_reg[2]) begin
                        next_op_kind   = `DTD_K_ILLEGAL;
                        next_op_clocks = 5'h00;
                     end else begin
                        next_op_kind   = `DTD_K_STSEG;
                        next_op_clocks = stseg_cost;
                     end
                  end
                  `DTD_OP_LOAD_EO: begin
                     next_op_kind   = `DTD_K_LEO;
                     next_op_clocks = `DTD_CLK_LEO;
                  end
                  `DTD_OP_LOAD_FP_DATA: begin
                     // Far pointer needs a memory operand
                     if (mb_is_reg) begin
                        next_op_kind   = `DTD_K_ILLEGAL;
                        next_op_clocks = 5'h00;
                     end else begin
                        next_op_kind   = `DTD_K_LFPDS;
                        next_op_clocks = `DTD_CLK_LFP;
                     end
                  end
                  `DTD_OP_LOAD_FP_EXTRA: begin
                     if (mb_is_reg) begin
                        next_op_kind   = `DTD_K_ILLEGAL;
                        next_op_clocks = 5'h00;
                     end else begin
                        next_op_kind   = `DTD_K_LFPES;
                        next_op_clocks = `DTD_CLK_LFP;
                     end
                  end
                  default: begin
                     // Immediate move needs reg field 000
                     next_op_word = opc[0];
                     if (mb_reg == 3'h0) begin
                        next_op_kind   = `DTD_K_MOVIMM;
                        next_op_clocks = movimm_cost;
                        next_state     = ST_IMM_L;
                     end else begin
                        next_op_kind   = `DTD_K_ILLEGAL;
                        next_op_clocks = 5'h00;
                     end
                  end
               endcase
            end
         end
         ST_IMM_L: begin
            if (take) begin
               next_op_imm[7:0] = byte_i;
               next_state       = opc[0] ? ST_IMM_H : ST_OUT;
            end
         end
         ST_IMM_H: begin
            if (take) begin
               next_op_imm[15:8] = byte_i;
               next_state        = ST_OUT;
            end
         end
         ST_OUT: begin
            // Present result until execution unit accepts it
            if (!op_valid_o) begin
               next_op_valid   = 1'b1;
               next_op_seg_ovr = ovr_pend;
               next_op_seg     = ovr_seg;
            end else if (op_ready_i) begin
               next_op_valid = 1'b0;
               next_ovr_pend = 1'b0; // Override spent on this operand
               next_state    = ST_OPC;
            end
         end
         default: begin
            next_state = ST_OPC;
         end
      endcase
   end

   // State and result registers
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         state        <= ST_OPC;
         opc          <= 8'h00;
         ovr_pend     <= 1'b0;
         ovr_seg      <= `DTD_SEG_DATA;
         op_valid_o   <= 1'b0;
         op_kind_o    <= `DTD_K_NONE;
         op_word_o    <= 1'b0;
         op_mode_o    <= 2'h0;
         op_reg_o     <= 3'h0;
         op_rm_o      <= 3'h0;
         op_imm_o     <= 16'h0000;
         op_clocks_o  <= 5'h00;
         op_seg_ovr_o <= 1'b0;
         op_seg_o     <= 2'h0;
         pfx_valid_o  <= 1'b0;
         pfx_clocks_o <= 5'h00;
      end else begin
         state        <= next_state;
         opc          <= next_opc;
         ovr_pend     <= next_ovr_pend;
         ovr_seg      <= next_ovr_seg;
         op_valid_o   <= next_op_valid;
         op_kind_o    <= next_op_kind;
         op_word_o    <= next_op_word;
         op_mode_o    <= next_op_mode;
         op_reg_o     <= next_op_reg;
         op_rm_o      <= next_op_rm;
         op_imm_o     <= next_op_imm;
         op_clocks_o  <= next_op_clocks;
         op_seg_ovr_o <= next_op_seg_ovr;
         op_seg_o     <= next_op_seg;
         pfx_valid_o  <= next_pfx_valid;
         pfx_clocks_o <= next_pfx_clocks;
      end
   end

endmodule // dtd_decoder

// [common/dtd_defines.vh]
`ifndef DTD_DEFINES_VH
`define DTD_DEFINES_VH

// Opcode bytes
`define DTD_OP_MOV_IMM_RM   7'h63
`define DTD_OP_MOV_RM_SEG   8'h8e
`define DTD_OP_MOV_SEG_RM   8'h8c
`define DTD_OP_TABLE_LOOKUP 8'hd7
`define DTD_OP_LOAD_EO      8'h8d
`define DTD_OP_LOAD_FP_DATA  8'hc5
`define DTD_OP_LOAD_FP_EXTRA 8'hc4
`define DTD_OP_FLAGS_TO_ACCH 8'h9f
`define DTD_OP_ACCH_TO_FLAGS 8'h9e
`define DTD_PFX_CODE        8'h2e
`define DTD_PFX_STACK       8'h36
`define DTD_PFX_DATA        8'h3e
`define DTD_PFX_EXTRA       8'h26

// Addressing byte fields
`define DTD_MOD_HI   7
`define DTD_MOD_LO   6
`define DTD_REG_HI   5
`define DTD_REG_LO   3
`define DTD_MOD_REG  2'h3

// Operation codes reported to the execution unit
`define DTD_K_NONE   4'h0
`define DTD_K_MOVIMM 4'h1
`define DTD_K_LDSEG  4'h2
`define DTD_K_STSEG  4'h3
`define DTD_K_TBL    4'h4
`define DTD_K_LEO    4'h5
`define DTD_K_LFPDS  4'h6
`define DTD_K_LFPES  4'h7
`define DTD_K_F2AH   4'h8
`define DTD_K_AH2F   4'h9
`define DTD_K_ILLEGAL 4'hf

// Segment encodings
`define DTD_SEG_EXTRA 2'h0
`define DTD_SEG_CODE  2'h1
`define DTD_SEG_STACK 2'h2
`define DTD_SEG_DATA  2'h3

// Clock counts
`define DTD_CLK_MOVIMM_B 5'h0c
`define DTD_CLK_MOVIMM_W 5'h0d
`define DTD_CLK_LDSEG_R  5'h02
`define DTD_CLK_LDSEG_M  5'h09
`define DTD_CLK_STSEG_R  5'h02
`define DTD_CLK_STSEG_M  5'h0b
`define DTD_CLK_TBL      5'h0b
`define DTD_CLK_LEO      5'h06
`define DTD_CLK_LFP      5'h12
`define DTD_CLK_F2AH     5'h02
`define DTD_CLK_AH2F     5'h03
`define DTD_CLK_PREFIX   5'h02

`endif

// [verilog/dtd_cost_sel.v]
`include "dtd_defines.vh"

// Picks register or memory clock count from the addressing mode
module dtd_cost_sel (
   input  wire [1:0] mode_i,
   input  wire [4:0] reg_cost_i,
   input  wire [4:0] mem_cost_i,
   output wire [4:0] cost_o
);

   // Mode 11 names a register operand
   assign cost_o = (mode_i == `DTD_MOD_REG) ? reg_cost_i : mem_cost_i;

endmodule // dtd_cost_sel

// [verification/dtd_decoder_properties.sv]
module dtd_decoder_properties (
   input logic        clk_i,
   input logic        rst_n_i,
   input logic        byte_ready_o,
   input logic        op_valid_o,
   input logic        op_ready_i,
   input logic [3:0]  op_kind_o,
   input logic        op_word_o,
   input logic [1:0]  op_mode_o,
   input logic [2:0]  op_reg_o,
   input logic [15:0] op_imm_o,
   input logic [4:0]  op_clocks_o,
   input logic        pfx_valid_o,
   input logic [4:0]  pfx_clocks_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Clock count checks on each presented op, width check on immediate moves
   movimm_cost_a: assert property (op_valid_o && op_kind_o == 4'h1 |->
      op_clocks_o == (op_word_o ? 5'h0d : 5'h0c) && (op_word_o || op_imm_o[15:8] == 8'h00))
      else $error("immediate move cost wrong");
   ldseg_cost_a: assert property (op_valid_o && op_kind_o == 4'h2 |->
      !op_reg_o[2] && op_clocks_o == (op_mode_o == 2'h3 ? 5'h02 : 5'h09))
      else $error("segment load cost wrong");
   stseg_cost_a: assert property (op_valid_o && op_kind_o == 4'h3 |->
      op_clocks_o == (op_mode_o == 2'h3 ? 5'h02 : 5'h0b)) else $error("segment store cost wrong");
   table_cost_a: assert property (op_valid_o && op_kind_o == 4'h4 |->
      op_clocks_o == 5'h0b && !byte_ready_o) else $error("table lookup cost wrong");
   leo_cost_a: assert property (op_valid_o && op_kind_o == 4'h5 |->
      op_clocks_o == 5'h06) else $error("offset load cost wrong");
   far_data_a: assert property (op_valid_o && op_kind_o == 4'h6 |->
      op_clocks_o == 5'h12 && op_mode_o != 2'h3) else $error("far pointer data wrong");
   far_extra_a: assert property (op_valid_o && op_kind_o == 4'h7 |->
      op_clocks_o == 5'h12 && op_mode_o != 2'h3) else $error("far pointer extra wrong");
   flag_load_a: assert property (op_valid_o && op_kind_o == 4'h8 |->
      op_clocks_o == 5'h02) else $error("flags to acc cost wrong");
   flag_store_a: assert property (op_valid_o && op_kind_o == 4'h9 |->
      op_clocks_o == 5'h03) else $error("acc to flags cost wrong");
   pfx_cost_a: assert property (pfx_valid_o |-> pfx_clocks_o == 5'h02)
      else $error("prefix cost wrong");
   // A waiting op keeps its count until taken
   op_hold_a: assert property (op_valid_o && !op_ready_i |=>
      op_valid_o && $stable(op_clocks_o) && $stable(op_kind_o)) else $error("op not held");
   // Refused forms carry no clock count
   illegal_cost_a: assert property (op_valid_o && op_kind_o == 4'hf |->
      op_clocks_o == 5'h00) else $error("refused form has a cost");
   // No byte or prefix taken while an op waits
   ready_block_a: assert property (op_valid_o |->
      !byte_ready_o && !pfx_valid_o) else $error("byte taken while op waits");
endmodule // dtd_decoder_properties

bind dtd_decoder dtd_decoder_properties dtd_decoder_properties_inst (
   .clk_i        (clk_i),
   .rst_n_i      (rst_n_i),
   .byte_ready_o (byte_ready_o),
   .op_valid_o   (op_valid_o),
   .op_ready_i   (op_ready_i),
   .op_kind_o    (op_kind_o),
   .op_word_o    (op_word_o),
   .op_mode_o    (op_mode_o),
   .op_reg_o     (op_reg_o),
   .op_imm_o     (op_imm_o),
   .op_clocks_o  (op_clocks_o),
   .pfx_valid_o  (pfx_valid_o),
   .pfx_clocks_o (pfx_clocks_o)
);

// [verification/dtd_exec_model.sv]
module dtd_exec_model (
   input  logic       clk_i,
   input  logic       rst_n_i,
   input  logic       valid_i,
   input  logic [3:0] stall_i,
   output logic       ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_cnt;
   // Execution unit takes an op after stall_i + 1 busy cycles
   always @(posedge clk_i) begin
      if (!rst_n_i || (valid_i && ready_o)) begin
         wait_cnt <= 4'h0;
         ready_o  <= 1'b0;
      end else if (valid_i) begin
         wait_cnt <= wait_cnt + 4'h1;
         ready_o  <= (wait_cnt >= stall_i);
      end
   end
endmodule // dtd_exec_model

// [verification/dtd_decoder_tb_top.sv]
module dtd_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, rst_n_i, byte_valid_i, byte_ready_o, op_valid_o, op_ready_i;
   logic        op_word_o, op_seg_ovr_o, pfx_valid_o;
   logic [7:0]  byte_i;
   logic [3:0]  op_kind_o, stall;
   logic [1:0]  op_mode_o, op_seg_o;
   logic [2:0]  op_reg_o, op_rm_o, got_seg;
   logic [15:0] op_imm_o, got_imm;
   logic [8:0]  got_fld;
   logic [4:0]  op_clocks_o, pfx_clocks_o;
   int          errors, n_compared, pfx_seen, i;
   dtd_decoder dtd_decoder_inst (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .byte_i       (byte_i),
      .byte_valid_i (byte_valid_i),
      .byte_ready_o (byte_ready_o),
      .op_valid_o   (op_valid_o),
      .op_ready_i   (op_ready_i),
      .op_kind_o    (op_kind_o),
      .op_word_o    (op_word_o),
      .op_mode_o    (op_mode_o),
      .op_reg_o     (op_reg_o),
      .op_rm_o      (op_rm_o),
      .op_imm_o     (op_imm_o),
      .op_clocks_o  (op_clocks_o),
      .op_seg_ovr_o (op_seg_ovr_o),
      .op_seg_o     (op_seg_o),
      .pfx_valid_o  (pfx_valid_o),
      .pfx_clocks_o (pfx_clocks_o)
   );
   dtd_exec_model dtd_exec_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .valid_i(op_valid_o), .stall_i(stall), .ready_o(op_ready_i));
   // Clock and prefix pulse counter
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (rst_n_i && pfx_valid_o === 1'b1) pfx_seen++;
   task chk(input logic [15:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Feed n bytes, wait for the op, compare kind and count
   task run(input logic [31:0] b, input int n, input logic [3:0] k, input logic [4:0] c);
      for (i = 0; i < n; i++) begin
         byte_i <= b[31-8*i -: 8];
         byte_valid_i <= 1'b1;
         do @(negedge clk_i); while (byte_ready_o !== 1'b1);
         @(posedge clk_i);
      end
      byte_valid_i <= 1'b0;
      i = 0;
      do begin
         @(negedge clk_i);
         i++;
      end while (!(op_valid_o === 1'b1 && op_ready_i === 1'b1) && i < 60);
      if (op_valid_o !== 1'b1 || op_ready_i !== 1'b1) begin
         errors++;
         $display("[ERR] %0t no op presented", $time);
      end
      chk(op_kind_o, k);
      chk(op_clocks_o, c);
      got_seg = {op_seg_ovr_o, op_seg_o};
      got_imm = op_imm_o;
      got_fld = {op_word_o, op_mode_o, op_reg_o, op_rm_o};
      @(posedge clk_i);
   endtask
   task t_move;
      stall <= 4'h0;
      run(32'hc6005500, 3, 4'h1, 5'h0c);
      chk(got_imm, 16'h0055);
      chk(got_fld, 9'h000);
      run(32'hc7c03412, 4, 4'h1, 5'h0d);
      chk(got_imm, 16'h1234);
      chk(got_fld, 9'h1c0);
      run(32'hc6080000, 2, 4'hf, 5'h00);
      $display("move test done");
   endtask
   task t_seg;
      stall <= 4'h3;
      run(32'h8ec00000, 2, 4'h2, 5'h02);
      run(32'h8e180000, 2, 4'h2, 5'h09);
      chk(got_fld, 9'h118);
      run(32'h8e200000, 2, 4'hf, 5'h00);
      run(32'h8cc80000, 2, 4'h3, 5'h02);
      chk(got_fld, 9'h1c8);
      run(32'h8c000000, 2, 4'h3, 5'h0b);
      $display("segment test done");
   endtask
   task t_ptr;
      stall <= 4'h1;
      run(32'h8d5e0000, 2, 4'h5, 5'h06);
      chk(got_fld, 9'h15e);
      run(32'hc5000000, 2, 4'h6, 5'h12);
      run(32'hc5c00000, 2, 4'hf, 5'h00);
      run(32'hc4000000, 2, 4'h7, 5'h12);
      run(32'hc4c00000, 2, 4'hf, 5'h00);
      $display("pointer test done");
   endtask
   task t_single;
      stall <= 4'h5;
      run(32'hd7000000, 1, 4'h4, 5'h0b);
      run(32'h9f000000, 1, 4'h8, 5'h02);
      chk(got_fld, 9'h000);
      run(32'h9e000000, 1, 4'h9, 5'h03);
      $display("single byte test done");
   endtask
   // Each prefix steers the next op, then is cleared
   task t_pfx;
      logic [7:0] pf [4];
      pf = '{8'h2e, 8'h36, 8'h3e, 8'h26};
      stall <= 4'h0;
      for (int j = 0; j < 4; j++) begin
         run({pf[j], 24'hd70000}, 2, 4'h4, 5'h0b);
         chk(got_seg, {1'b1, 2'(j + 1)});
      end
      run(32'hd7000000, 1, 4'h4, 5'h0b);
      chk(got_seg, 3'h0);
      chk(pfx_seen[15:0], 16'h0004);
      chk(pfx_clocks_o, 16'h0002);
      $display("prefix test done");
   endtask
   task finish_test;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #(25ns * 4000);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test;
   end
   initial begin
      errors = 0;
      n_compared = 0;
      pfx_seen = 0;
      rst_n_i = 1'b0;
      byte_valid_i = 1'b0;
      byte_i = 8'h00;
      stall = 4'h0;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_move;
      t_seg;
      t_ptr;
      t_single;
      t_pfx;
      finish_test;
   end
endmodule // dtd_decoder_tb_top
